/* File: hw/clksw_pkg.sv */
// clksw_pkg: constants, types and state layout of the
// system clock switch and start-up block.
// assumes pclk at 125 MHz and an APB master with 32-bit data.
package clksw_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_SEL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CAUSE = 8'h0C;
    localparam int SEL_BIT = 0;
    localparam int SECEN_BIT = 0;
    localparam int STAT_CUR_BIT = 0;
    localparam int STAT_RUN_BIT = 1;
    localparam int STAT_SLP_BIT = 2;
    localparam int CLK_MHZ = 125;
    localparam int POWERUP_TIMER_MS = 72;
    localparam int PLL_MS = 2;
    localparam int POWERUP_TIMER_CYC = POWERUP_TIMER_MS * 1000 * CLK_MHZ;
    localparam int PLL_CYC = PLL_MS * 1000 * CLK_MHZ;
    localparam int EDGE_CNT = 8;
    localparam int OST_CNT = 1024;
    localparam int FILT_CYC = 4;
    localparam int FILT_W = 3;
    localparam int CNT_W = 24;

    typedef enum logic [2:0] {
        M_LP, M_XT, M_HS, M_RC, M_EC, M_HSPLL, M_RESISTOR_CAPACITOR_IO_MODE, M_EXTERNAL_CLOCK_IO_MODE
    } clksw_mode_t;
    // zero-coded first entries give the power-on values
    typedef enum logic [2:0] {
        ST_POWERUP_TIMER, ST_OST, ST_PLL, ST_SYNC, ST_RUN, ST_SLEEP
    } clksw_state_t;
    typedef enum logic [3:0] {
        C_POR, C_EXTERNAL_RESET_PIN_RUN, C_EXTERNAL_RESET_PIN_SLP, C_WDT, C_BOR, C_INSTR,
        C_STK_FULL, C_STK_UNDER, C_WDT_WAKE, C_IRQ_WAKE
    } clksw_cause_t;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } clksw_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } clksw_apb_rsp_t;
    typedef struct packed {
        logic wdt;
        logic bor;
        logic instr;
        logic stk_full;
        logic stk_under;
        logic irq;
        logic sleep;
    } clksw_evt_t;
    typedef struct packed {
        logic gate_main;
        logic gate_sec;
        logic cpu_run;
        logic core_run;
        logic pll_en;
        logic osc_stop;
        logic fb_en;
        logic oscillator_output_pin_o;
        logic oscillator_output_pin_oe;
        logic oscillator_output_pin_port_bit6;
        logic external_reset_pin_oe;
    } clksw_out_t;
    typedef struct packed {
        clksw_state_t st;
        logic tgt_sec;
        logic cur_sec;
        logic sel;
        logic sec_en;
        logic slp_pend;
        logic booted;
        logic [1:0] q;
        logic [CNT_W-1:0] cnt;
        logic [2:0] m_sync;
        logic [2:0] s_sync;
        logic [1:0] r_sync;
        logic [FILT_W-1:0] filt;
        logic external_reset_pin_hit;
        clksw_cause_t cause;
        clksw_apb_rsp_t rsp;
        clksw_out_t out;
    } clksw_regs_t;
endpackage

/* File: hw/clksw_top.sv */
// clksw_top: system clock select, glitch-free switch,
// start-up timers, sleep and reset-source tracking.
// assumes oscillator pins and reset pin are asynchronous,
// core events arrive as pclk pulses, registers over APB.
`timescale 1ns/1ps
module clksw_top #(
    parameter int POWERUP_TIMER_CYCLES = clksw_pkg::POWERUP_TIMER_CYC,
    parameter int PLL_CYCLES = clksw_pkg::PLL_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire clksw_pkg::clksw_apb_req_t apb_req,
    output clksw_pkg::clksw_apb_rsp_t apb_rsp,
    input wire clksw_pkg::clksw_mode_t main_osc_config,
    input wire logic clock_switch_enable,
    input wire logic powerup_timer_en,
    input wire logic oscillator_input_pin,
    input wire logic secondary_osc_pin,
    input wire logic external_reset_pin_n,
    input wire clksw_pkg::clksw_evt_t core_evt,
    output clksw_pkg::clksw_out_t clk_out
);
    import clksw_pkg::*;

    clksw_regs_t s_reg;
    clksw_regs_t s_next;
    logic m_rise;
    logic s_rise;
    logic sync_edge;
    logic crystal;
    logic pll;
    logic rcec_drv;
    logic io_mode;
    logic allow;
    logic external_reset_pin_evt;
    logic rst_evt;
    logic acc;
    logic hit;
    logic wr;
    logic [31:0] rdata;

    ////////////////////////////////////////////////////////
    // decode of inputs; sync stage 0 feeds stage 1 only
    assign m_rise = s_reg.m_sync[1] & ~s_reg.m_sync[2];
    assign s_rise = s_reg.s_sync[1] & ~s_reg.s_sync[2];
    assign sync_edge = s_reg.tgt_sec ? s_rise : m_rise;
    assign crystal = main_osc_config inside {M_LP, M_XT, M_HS, M_HSPLL};
    assign pll = main_osc_config == M_HSPLL;
    assign rcec_drv = main_osc_config inside {M_RC, M_EC};
    assign io_mode = main_osc_config inside {M_RESISTOR_CAPACITOR_IO_MODE, M_EXTERNAL_CLOCK_IO_MODE};
    // enable bit programmed to 0 allows switching
    assign allow = s_reg.sec_en & ~clock_switch_enable;
    // a low level must survive the filter before it counts
    assign external_reset_pin_evt = ~s_reg.r_sync[1] & ~s_reg.external_reset_pin_hit
        & (s_reg.filt == FILT_W'(FILT_CYC - 1));
    assign rst_evt = external_reset_pin_evt | (core_evt.wdt & s_reg.st != ST_SLEEP)
        | core_evt.bor | core_evt.instr | core_evt.stk_full
        | core_evt.stk_under;
    assign acc = apb_req.psel & apb_req.penable;
    assign hit = apb_req.paddr inside {OFF_SEL, OFF_CTL, OFF_STAT, OFF_CAUSE};
    assign wr = acc & s_reg.rsp.pready & apb_req.pwrite;

    always_comb begin
        rdata = '0;
        unique case (apb_req.paddr)
            OFF_SEL: rdata[SEL_BIT] = s_reg.sel;
            OFF_CTL: rdata[SECEN_BIT] = s_reg.sec_en;
            OFF_STAT: begin
                rdata[STAT_CUR_BIT] = s_reg.cur_sec;
                rdata[STAT_RUN_BIT] = s_reg.out.cpu_run;
                rdata[STAT_SLP_BIT] = s_reg.st == ST_SLEEP;
            end
            OFF_CAUSE: rdata[3:0] = s_reg.cause;
            default: rdata = '0;
        endcase
    end

    ////////////////////////////////////////////////////////
    always_comb begin
        s_next = s_reg;
        s_next.m_sync = {s_reg.m_sync[1:0], oscillator_input_pin};
        s_next.s_sync = {s_reg.s_sync[1:0], secondary_osc_pin};
        s_next.r_sync = {s_reg.r_sync[0], external_reset_pin_n};
        if (s_reg.r_sync[1]) begin
            s_next.filt = '0;
            s_next.external_reset_pin_hit = 1'b0;
        end else if (s_reg.filt != FILT_W'(FILT_CYC - 1)) begin
            s_next.filt = s_reg.filt + FILT_W'(1);
        end else begin
            s_next.external_reset_pin_hit = 1'b1;
        end

        // one wait state: answer in the second cycle after setup
        s_next.rsp.pready = acc & ~s_reg.rsp.pready;
        s_next.rsp.pslverr = acc & ~s_reg.rsp.pready & ~hit;
        if (acc & ~s_reg.rsp.pready) begin
            s_next.rsp.prdata = rdata;
        end
        if (wr & apb_req.paddr == OFF_CTL) begin
            s_next.sec_en = apb_req.pwdata[SECEN_BIT];
        end
        if (wr & apb_req.paddr == OFF_SEL) begin
            s_next.sel = apb_req.pwdata[SEL_BIT];
        end
        if (!allow) begin
            s_next.sel = 1'b0;
        end
        unique case (s_reg.st)
            ST_POWERUP_TIMER: begin
                if (!powerup_timer_en || s_reg.cnt == CNT_W'(POWERUP_TIMER_CYCLES - 1)) begin
                    s_next.cnt = '0;
                    s_next.st = crystal ? ST_OST : ST_SYNC;
                end else begin
                    s_next.cnt = s_reg.cnt + CNT_W'(1);
                end
            end
            ST_OST: begin
                if (m_rise) begin
                    if (s_reg.cnt == CNT_W'(OST_CNT - 1)) begin
                        s_next.cnt = '0;
                        s_next.st = pll ? ST_PLL : ST_SYNC;
                    end else begin
                        s_next.cnt = s_reg.cnt + CNT_W'(1);
                    end
                end
            end
            ST_PLL: begin
                if (s_reg.cnt == CNT_W'(PLL_CYCLES - 1)) begin
                    s_next.cnt = '0;
                    s_next.st = ST_SYNC;
                end else begin
                    s_next.cnt = s_reg.cnt + CNT_W'(1);
                end
            end
            ST_SYNC: begin
                if (sync_edge) begin
                    if (s_reg.cnt == CNT_W'(EDGE_CNT - 1)) begin
                        s_next.cnt = '0;
                        s_next.st = ST_RUN;
                        s_next.cur_sec = s_reg.tgt_sec;
                        s_next.booted = 1'b1;
                        s_next.out.gate_sec = s_reg.tgt_sec;
                        s_next.out.gate_main = ~s_reg.tgt_sec;
                    end else begin
                        s_next.cnt = s_reg.cnt + CNT_W'(1);
                    end
                end
            end
            ST_RUN: begin
                if (s_reg.q != 2'h0) begin
                    s_next.q = s_reg.q + 2'h1;
                end else if (s_reg.sel != s_reg.cur_sec) begin
                    // stop at first quarter, both gates low first
                    s_next.out.gate_main = 1'b0;
                    s_next.out.gate_sec = 1'b0;
                    s_next.tgt_sec = s_reg.sel;
                    s_next.st = (!s_reg.sel && crystal) ? ST_OST : ST_SYNC;
                end else if (s_reg.slp_pend) begin
                    s_next.slp_pend = 1'b0;
                    s_next.out.gate_main = 1'b0;
                    s_next.out.gate_sec = 1'b0;
                    s_next.st = ST_SLEEP;
                end else begin
                    s_next.q = s_reg.q + 2'h1;
                end
            end
            ST_SLEEP: begin
                // watchdog here only wakes; registers other than cause stay
                if (core_evt.irq | core_evt.wdt) begin
                    s_next.cause = core_evt.wdt ? C_WDT_WAKE : C_IRQ_WAKE;
                    s_next.tgt_sec = s_reg.cur_sec;
                    s_next.st = (crystal && !s_reg.cur_sec) ? ST_OST : ST_SYNC;
                end
            end
            default: s_next.st = ST_POWERUP_TIMER;
        endcase

        // a sleep request in the entry cycle is kept: set wins over clear
        if (core_evt.sleep & s_reg.st == ST_RUN) begin
            s_next.slp_pend = 1'b1;
        end

        if (rst_evt) begin
            s_next.sel = 1'b0;
            s_next.cur_sec = 1'b0;
            s_next.tgt_sec = 1'b0;
            s_next.sec_en = 1'b0;
            s_next.slp_pend = 1'b0;
            s_next.booted = 1'b0;
            s_next.q = '0;
            s_next.cnt = '0;
            s_next.out.gate_main = 1'b0;
            s_next.out.gate_sec = 1'b0;
            if (core_evt.bor) begin
                s_next.st = ST_POWERUP_TIMER;
            end else if (external_reset_pin_evt && s_reg.st == ST_SLEEP) begin
                s_next.st = crystal ? ST_OST : ST_SYNC;
            end else begin
                s_next.st = ST_SYNC;
            end
            if (external_reset_pin_evt) begin
                s_next.cause = s_reg.st == ST_SLEEP ? C_EXTERNAL_RESET_PIN_SLP : C_EXTERNAL_RESET_PIN_RUN;
            end else if (core_evt.wdt) begin
                s_next.cause = C_WDT;
            end else if (core_evt.bor) begin
                s_next.cause = C_BOR;
            end else if (core_evt.instr) begin
                s_next.cause = C_INSTR;
            end else if (core_evt.stk_full) begin
                s_next.cause = C_STK_FULL;
            end else begin
                s_next.cause = C_STK_UNDER;
            end
        end

        s_next.out.cpu_run = s_next.st == ST_RUN;
        s_next.out.core_run = s_next.booted;
        s_next.out.pll_en = pll;
        s_next.out.osc_stop = s_next.st == ST_SLEEP;
        s_next.out.fb_en = crystal & s_next.st != ST_SLEEP;
        // pclk/4 from q[1] on the pin while running, low in sleep
        s_next.out.oscillator_output_pin_oe = rcec_drv;
        s_next.out.oscillator_output_pin_o = s_next.st != ST_SLEEP & s_next.q[1];
        s_next.out.oscillator_output_pin_port_bit6 = io_mode;
        s_next.out.external_reset_pin_oe = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign apb_rsp = s_reg.rsp;
    assign clk_out = s_reg.out;

    ////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_sync_last;
        s_reg.st == ST_SYNC && sync_edge && !rst_evt
            && s_reg.cnt == CNT_W'(EDGE_CNT - 1);
    endsequence
    sequence s_ost_done;
        s_reg.st == ST_OST && m_rise && !rst_evt
            && s_reg.cnt == CNT_W'(OST_CNT - 1);
    endsequence

    AST_SYNC_EIGHT: assert property (s_sync_last |=> s_reg.st == ST_RUN
        && s_reg.cur_sec == $past(s_reg.tgt_sec))
        else $error("run not entered after eighth edge");
    AST_SYNC_EARLY: assert property (s_reg.st == ST_SYNC && !rst_evt
        && s_reg.cnt < CNT_W'(EDGE_CNT - 1) |=> s_reg.st != ST_RUN)
        else $error("resumed before eight edges");
    AST_PLL_AFTER_OST: assert property (s_ost_done ##0 pll
        |=> s_reg.st == ST_PLL)
        else $error("lock wait skipped");
    AST_OST_CRYSTAL: assert property (s_reg.st == ST_OST |-> crystal)
        else $error("start-up timer in non-crystal mode");
    AST_SEL_ALLOWED: assert property (s_reg.sel |-> $past(allow))
        else $error("select set while switching not allowed");
    AST_RST_CLR: assert property (rst_evt |=> !s_reg.sel
        && !s_reg.cur_sec ##1 !clk_out.gate_sec)
        else $error("reset left secondary selected");
    AST_SEL_READ: assert property (apb_rsp.pready && !apb_req.pwrite
        && apb_req.paddr == OFF_SEL |-> apb_rsp.prdata[31:1] == '0)
        else $error("upper select bits not zero");
    AST_NO_OVERLAP: assert property (!(clk_out.gate_main
        && clk_out.gate_sec))
        else $error("both sources gated together");
    AST_FREEZE_Q1: assert property ($fell(clk_out.cpu_run)
        && !$past(rst_evt) |-> $past(s_reg.q) == 2'h0)
        else $error("freeze not at first quarter");
    AST_SLEEP_PIN: assert property (s_reg.st == ST_SLEEP && rcec_drv
        |=> clk_out.oscillator_output_pin_oe && !clk_out.oscillator_output_pin_o)
        else $error("output pin not low in sleep");
    AST_EXTERNAL_RESET_PIN_OE: assert property (!clk_out.external_reset_pin_oe)
        else $error("reset pin driven");
    AST_POWERUP_TIMER_SKIP: assert property (s_reg.st == ST_POWERUP_TIMER
        && !powerup_timer_en && !rst_evt |=> s_reg.st != ST_POWERUP_TIMER)
        else $error("power-up timer ran while disabled");

    // stepwise checks of timers, sleep and reset handling
    sequence s_sleep_stay;
        s_reg.st == ST_SLEEP && !rst_evt;
    endsequence

    AST_OST_TO_SYNC: assert property (s_ost_done ##0 !pll
        |=> s_reg.st == ST_SYNC)
        else $error("crystal start-up did not lead to sync");
    AST_PLL_WAIT: assert property (s_reg.st == ST_PLL && !rst_evt
        && s_reg.cnt != CNT_W'(PLL_CYCLES - 1) |=> s_reg.st == ST_PLL)
        else $error("lock wait cut short");
    AST_OST_HOLD: assert property (s_reg.st == ST_OST && !m_rise
        && !rst_evt |=> s_reg.st == ST_OST && $stable(s_reg.cnt))
        else $error("start-up count moved without a main edge");
    AST_OST_FULL: assert property (s_reg.st == ST_OST && !rst_evt
        && s_reg.cnt != CNT_W'(OST_CNT - 1) |=> s_reg.st == ST_OST)
        else $error("start-up ended before full count");
    AST_SLEEP_STOP: assert property (s_reg.st == ST_SLEEP |-> clk_out.osc_stop
        && !clk_out.cpu_run && !clk_out.gate_main && !clk_out.gate_sec)
        else $error("clocks running in sleep");
    AST_SLEEP_AT_Q1: assert property (s_reg.st == ST_RUN && s_next.st == ST_SLEEP
        |-> s_reg.q == 2'h0)
        else $error("sleep entered off first quarter");
    AST_WAKE_IRQ: assert property (s_sleep_stay ##0 core_evt.irq
        |=> s_reg.st inside {ST_OST, ST_SYNC})
        else $error("interrupt did not wake");
    AST_WAKE_WDT: assert property (s_sleep_stay ##0 core_evt.wdt
        |=> s_reg.booted && s_reg.cause == C_WDT_WAKE && s_reg.st != ST_POWERUP_TIMER)
        else $error("watchdog wake treated as reset");
    AST_FILTER: assert property (external_reset_pin_evt |-> !$past(s_reg.r_sync[1])
        && !$past(s_reg.r_sync[1], 2) && !$past(s_reg.r_sync[1], 3))
        else $error("short pin pulse caused reset");
    AST_BOR_POWERUP_TIMER: assert property (core_evt.bor
        |=> s_reg.st == ST_POWERUP_TIMER)
        else $error("brown-out skipped power-up timer");
    AST_POWERUP_TIMER_OST: assert property (s_reg.st == ST_POWERUP_TIMER && s_next.st != ST_POWERUP_TIMER
        && !rst_evt && crystal |=> s_reg.st == ST_OST)
        else $error("start-up timer skipped after power-up");
    AST_CAUSE_WDT: assert property (core_evt.wdt && s_reg.st != ST_SLEEP
        && !external_reset_pin_evt |=> s_reg.cause == C_WDT)
        else $error("watchdog reset cause lost");
    AST_RST_REGS: assert property (rst_evt
        |=> !s_reg.sec_en && !s_reg.booted && !clk_out.core_run)
        else $error("reset left registers set");
    AST_SEC_OFF: assert property (!s_reg.sec_en
        |=> !s_reg.sel)
        else $error("select held without secondary enable");
    AST_PLL_MODE: assert property (clk_out.pll_en
        |-> $past(main_osc_config) == M_HSPLL)
        else $error("multiplier on outside its mode");
    AST_LEAVE_RUN: assert property (s_reg.st == ST_RUN && s_next.st != ST_RUN
        |=> !clk_out.gate_main && !clk_out.gate_sec)
        else $error("gate left on while leaving run");
endmodule

/* File: tb/clksw_osc_model.sv */
// clksw_osc_model: main and secondary oscillator sources for clksw_top.
// assumes the block raises stop while asleep; the secondary runs always.
`timescale 1ns/1ps
module clksw_osc_model #(
    parameter int MAIN_HALF_NS = 12,
    parameter int SEC_HALF_NS = 100
) (
    input wire logic stop,
    output logic main_clk,
    output logic sec_clk
);
////////////////////////////////////////////////////////////////////////
    // phase offsets keep both sources unrelated to pclk
    initial begin
        main_clk = 1'b1;
        #5;
        forever begin
            #(MAIN_HALF_NS);
            // stopped oscillator input floats, pulled high
            if (stop) begin
                main_clk = 1'b1;
            end else begin
                main_clk = ~main_clk;
            end
        end
    end

    initial begin
        sec_clk = 1'b0;
        #3;
        forever begin
            #(SEC_HALF_NS) sec_clk = ~sec_clk;
        end
    end
endmodule

/* File: tb/clksw_top_tb.sv */
// clksw_top_tb: register, switch, sleep and reset-source tests.
// assumes clksw_pkg, clksw_top and clksw_osc_model are compiled first.
`timescale 1ns/1ps
module clksw_top_tb;
    import clksw_pkg::*;
    localparam int MAIN_P = 3;
    localparam int SEC_P = 25;
    logic pclk;
    logic presetn;
    clksw_apb_req_t apb_req;
    clksw_apb_rsp_t apb_rsp;
    clksw_mode_t main_osc_config;
    logic clock_switch_enable;
    logic main_clk;
    logic sec_clk;
    logic external_reset_pin_n;
    clksw_evt_t core_evt;
    clksw_out_t clk_out;
    logic [31:0] rd;
    logic err;
    int failures;
    int n_checks;
    int cyc;
    int t0;
    clksw_evt_t evs [6] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h00};
    int causes [6] = '{3, 4, 5, 6, 7, 1};
    clksw_mode_t modes [3] = '{M_RC, M_RESISTOR_CAPACITOR_IO_MODE, M_XT};
    clksw_evt_t wakes [3] = '{7'h02, 7'h40, 7'h00};
    int wcause [3] = '{9, 8, 2};

    // short timer parameters keep the run brief
    clksw_top #(.POWERUP_TIMER_CYCLES(20), .PLL_CYCLES(10)) DUT (
        .pclk(pclk),
        .presetn(presetn),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .main_osc_config(main_osc_config),
        .clock_switch_enable(clock_switch_enable),
        .powerup_timer_en(1'b1),
        .oscillator_input_pin(main_clk),
        .secondary_osc_pin(sec_clk),
        .external_reset_pin_n(external_reset_pin_n),
        .core_evt(core_evt),
        .clk_out(clk_out)
    );
    clksw_osc_model osc (.stop(clk_out.osc_stop), .main_clk(main_clk), .sec_clk(sec_clk));
////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        apb_req <= '{a, 1'b1, 1'b0, wr, d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    // polls status; the watchdog is not the only guard against a hang
    task automatic wait_stat(input int b, input logic v);
        int i;
        for (i = 0; i < 3000; i++) begin
            apb(1'b0, OFF_STAT, 32'h0);
            if (rd[b] === v) break;
        end
        if (i == 3000) begin
            failures++;
            $display("[ERR] %0t status wait timed out", $time);
        end
    endtask

    task automatic pulse(input clksw_evt_t e);
        @(posedge pclk);
        core_evt <= e;
        @(posedge pclk);
        core_evt <= '0;
    endtask

    task automatic pin_low(input int n);
        @(posedge pclk);
        external_reset_pin_n <= 1'b0;
        repeat (n) @(posedge pclk);
        external_reset_pin_n <= 1'b1;
    endtask

    // upper select bits written high on purpose
    task automatic switch_to(input logic s, input int lo, input int hi);
        t0 = cyc;
        apb(1'b1, OFF_SEL, {31'h7F, s});
        wait_stat(STAT_RUN_BIT, 1'b0);
        wait_stat(STAT_RUN_BIT, 1'b1);
        chk(32'((cyc - t0 >= lo) && (cyc - t0 <= hi)), 32'h1);
        chk({rd[STAT_CUR_BIT], clk_out.gate_sec, clk_out.gate_main}, {s, s, ~s});
        apb(1'b0, OFF_SEL, 32'h0);
        chk(rd, {31'h0, s});
    endtask
////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        chk({clk_out.gate_main & clk_out.gate_sec, clk_out.external_reset_pin_oe}, 32'h0);
    end

    initial begin
        repeat (40000) @(posedge pclk);
        failures++;
        end_of_test();
    end

    initial begin
        failures = 0;
        n_checks = 0;
        presetn = 1'b0;
        apb_req = '0;
        main_osc_config = M_RC;
        clock_switch_enable = 1'b1;
        external_reset_pin_n = 1'b1;
        core_evt = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wait_stat(STAT_RUN_BIT, 1'b1);
        apb(1'b0, OFF_SEL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFF_CAUSE, 32'h0);
        chk(rd, 32'(C_POR));
        chk(32'(clk_out.pll_en), 32'h0);
        apb(1'b1, OFF_SEL, 32'hFF);
        apb(1'b0, OFF_SEL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, OFF_CTL, 32'h1);
        apb(1'b1, OFF_SEL, 32'h1);
        apb(1'b0, OFF_SEL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h10, 32'h1);
        chk(32'(err), 32'h1);
        clock_switch_enable <= 1'b0;
        switch_to(1'b1, 7 * SEC_P, 1500);
        switch_to(1'b0, 7 * MAIN_P, 1024 * MAIN_P);
        switch_to(1'b1, 7 * SEC_P, 1500);
        // glitch on the reset pin must not reset
        pin_low(2);
        repeat (12) @(posedge pclk);
        apb(1'b0, OFF_SEL, 32'h0);
        chk(rd, 32'h1);
        // back to main so each reset below starts from a real switch
        switch_to(1'b0, 7 * MAIN_P, 1024 * MAIN_P);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, OFF_CTL, 32'h1);
            switch_to(1'b1, 7 * SEC_P, 1500);
            if (evs[i] == '0) pin_low(8);
            else pulse(evs[i]);
            repeat (4) @(posedge pclk);
            wait_stat(STAT_RUN_BIT, 1'b1);
            chk(rd[STAT_CUR_BIT], 32'h0);
            apb(1'b0, OFF_CAUSE, 32'h0);
            chk(rd, 32'(causes[i]));
        end
        for (int i = 0; i < 3; i++) begin
            main_osc_config <= modes[i];
            apb(1'b1, OFF_CTL, 32'h1);
            pulse(7'h01);
            wait_stat(STAT_SLP_BIT, 1'b1);
            chk({clk_out.osc_stop, clk_out.cpu_run, clk_out.gate_main, clk_out.oscillator_output_pin_o},
                4'b1000);
            chk({clk_out.oscillator_output_pin_oe, clk_out.oscillator_output_pin_port_bit6, clk_out.fb_en},
                {modes[i] == M_RC, modes[i] == M_RESISTOR_CAPACITOR_IO_MODE, 1'b0});
            if (wakes[i] == '0) pin_low(8);
            else pulse(wakes[i]);
            wait_stat(STAT_RUN_BIT, 1'b1);
            apb(1'b0, OFF_CAUSE, 32'h0);
            chk(rd, 32'(wcause[i]));
            apb(1'b0, OFF_CTL, 32'h0);
            chk(rd, {31'h0, wakes[i] != '0});
        end
        // crystal main needs the start-up count before resuming
        apb(1'b1, OFF_CTL, 32'h1);
        switch_to(1'b1, 7 * SEC_P, 1500);
        switch_to(1'b0, 1031 * MAIN_P, 6000);
        main_osc_config <= M_HSPLL;
        switch_to(1'b1, 7 * SEC_P, 1500);
        chk(32'(clk_out.pll_en), 32'h1);
        // lock wait of 10 cycles set at the instance
        switch_to(1'b0, 1030 * MAIN_P + 10, 6000);
        end_of_test();
    end
endmodule
